// ==== hdl/cap_sense_compensation_config.sv ====
/*
 cap_sense_compensation_config: scan sequencer, offset compensation search,
 configuration load, working store access and non-volatile copy.
 assumes the analog front end answers each measure request with measDone and
 signed ticks, and the non-volatile memory is reached over a simple word port.
*/
// How it works
// - after one input is measured, store its ticks and measure the next enabled
// - each measurement repeats accumulate-transfer the configured repeat count
// - every input has its own repeat count in the working store
// - each input holds a 16-bit compensation value driving the offset converter
// - compensation runs at every power-up, driving each enabled input toward zero ticks
// - compensation values are kept for later scans, lost on reset
// - averaged ticks beyond positive or negative noise threshold restart compensation
// - periodic interval expiry restarts compensation regardless of thresholds
// - host compensation request honoured only in Active or Doze mode
// - raw ticks are low-pass filtered into a per-input average
// - deviation is raw ticks minus average, only given out on tickDeviation
// - at power-up valid non-volatile data is chosen, else fixed defaults
// - chosen source is copied to the working store, then only it is used
// - working store is lost on reset and reloaded afterwards
// - the fixed default store can never be written by the host
// - host writes sixteen registers through plain ports
// - host may overwrite working store at any time except during the load phase
// - on host signal the whole working store is copied to non-volatile memory
// - device follows the host-commanded operating mode
// - enabled inputs are visited in ascending order, first to last
// - interrupt asserted once compensation completes
// - interrupt asserted after working-store write and non-volatile copy finish
`timescale 1ns/1ps
`default_nettype none
module cap_sense_compensation_config #(
   parameter int N        = cscc_pkg::NUM_INPUTS,
   parameter int UNIT_CYC = cscc_pkg::PERIOD_UNIT_CYC
) (
   // clock and resets
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire logic                       softReset,
   // host control
   input  wire logic [1:0]                 hostMode,
   input  wire logic                       hostModeWr,
   input  wire logic                       hostCompReq,
   input  wire logic                       hostStoreWr,
   input  wire logic [3:0]                 hostStoreAddr,
   input  wire logic [7:0]                 hostStoreData,
   input  wire logic                       hostBurnReq,
   input  wire logic                       hostIrqAck,
   // front end
   output logic                            measStart,
   output logic [cscc_pkg::IDX_W-1:0]      measInput,
   output logic [cscc_pkg::REPEAT_W-1:0]   measRepeat,
   output logic [cscc_pkg::COMP_W-1:0]     pinOffsetValue,
   input  wire logic                       measDone,
   input  wire logic signed [cscc_pkg::TICK_W-1:0] measTicks,
   // non-volatile memory
   output logic                            nvmRd,
   output logic                            nvmWr,
   output logic [3:0]                      nvmAddr,
   output logic [7:0]                      nvmWrData,
   input  wire logic [7:0]                 nvmRdData,
   // status
   output logic [1:0]                      opMode,
   output logic                            compBusy,
   output logic                            configFromNvm,
   output logic signed [cscc_pkg::TICK_W-1:0] tickAverage,
   output logic signed [cscc_pkg::TICK_W-1:0] tickDeviation,
   output logic                            interruptRequest_n
);
   typedef struct packed {
      cscc_pkg::cscc_state_t st;
      logic [1:0]  mode;
      logic [4:0]  ldCnt;
      logic        srcNvm;
      logic [2:0]  idx;
      logic        comp;
      logic [4:0]  bitPos;
      logic        compDirty;
      logic [31:0] unitCnt;
      logic [7:0]  perCnt;
      logic        compPend;
      logic        irqN;
      logic        measStart;
      logic [7:0]  repeatCnt;
      logic        nvmRd;
      logic        nvmWr;
      logic [3:0]  nvmAddr;
      logic [7:0]  nvmData;
      logic [15:0] offOut;
      logic        burnPend;
      logic        pendIrq;
   } cscc_reg_t;

   cscc_reg_t r_q;
   cscc_reg_t r_d;
   logic [15:0] compVal_q [0:7];
   logic [15:0] compVal_d [0:7];

   logic       stWr;
   logic [3:0] stWrAddr;
   logic [7:0] stWrData;
   logic [3:0] stRdAddr;
   logic [7:0] stRdData;
   logic       filtValid;
   logic signed [15:0] filtAvg;
   logic signed [15:0] filtDev;
   logic       anyReset;

   // both reset sources end in the same power-up path
   assign anyReset = !rstn || softReset;

   cscc_store #(.AW(cscc_pkg::STORE_AW), .DW(cscc_pkg::STORE_DW)) uStore (
      .clk    (clk),
      .rstn   (!anyReset),
      .wrEn   (stWr),
      .wrAddr (stWrAddr),
      .wrData (stWrData),
      .rdAddr (stRdAddr),
      .rdData (stRdData)
   );

   cscc_filter #(.N(N), .IW(3), .TW(16), .SH(cscc_pkg::FILT_SHIFT)) uFilt (
      .clk           (clk),
      .rstn          (!anyReset),
      .sampleValid   (measDone && r_q.st == cscc_pkg::ST_WAIT && !r_q.comp),
      .sampleIdx     (r_q.idx),
      .sampleTicks   (measTicks),
      .tickAverage   (filtAvg),
      .tickDeviation (filtDev),
      .resultValid   (filtValid)
   );

   // next enabled input at or above start, 4'h8 when none
   function automatic logic [3:0] next_en(input logic [7:0] en, input logic [3:0] from);
      next_en = 4'h8;
      for (int i = 7; i >= 0; i--) begin
         if (en[i] && 4'(i) >= from) begin
            next_en = 4'(i);
         end
      end
   endfunction

   // enable mask, thresholds, period and repeat counts shadowed from store writes
   logic [7:0] enMask_q;
   logic [7:0] posTh_q;
   logic [7:0] negTh_q;
   logic [7:0] period_q;
   logic [7:0] rep_q [0:7];
   logic [3:0] nxt;

   always_ff @(posedge clk) begin
      if (anyReset) begin
         enMask_q <= 8'h00;
         posTh_q  <= 8'h00;
         negTh_q  <= 8'h00;
         period_q <= 8'h00;
         for (int i = 0; i < 8; i++) begin
            rep_q[i] <= 8'h00;
         end
      end else if (stWr) begin
         // shadow copy of what is written to the working store
         case (stWrAddr)
            cscc_pkg::ADDR_ENABLE:     enMask_q <= stWrData;
            cscc_pkg::ADDR_POS_THRESH: posTh_q  <= stWrData;
            cscc_pkg::ADDR_NEG_THRESH: negTh_q  <= stWrData;
            cscc_pkg::ADDR_PERIOD:     period_q <= stWrData;
            default: begin
               if (stWrAddr[3]) begin
                  rep_q[stWrAddr[2:0]] <= stWrData;
               end
            end
         endcase
      end
   end

   assign stRdAddr = r_d.nvmAddr;

   always_comb begin
      r_d = r_q;
      for (int i = 0; i < 8; i++) begin
         compVal_d[i] = compVal_q[i];
      end
      stWr     = 1'b0;
      stWrAddr = 4'h0;
      stWrData = 8'h00;
      nxt      = 4'h8;
      r_d.measStart = 1'b0;
      r_d.nvmRd     = 1'b0;
      r_d.nvmWr     = 1'b0;
      if (hostModeWr) begin
         r_d.mode = hostMode;
      end
      if (hostCompReq && r_q.mode != cscc_pkg::MODE_SLEEP) begin
         r_d.compPend = 1'b1;
      end
      if (hostBurnReq) begin
         r_d.burnPend = 1'b1;
      end
      if (filtValid && (filtAvg > $signed({8'h00, posTh_q}) ||
                        filtAvg < -$signed({8'h00, negTh_q}))) begin
         r_d.compPend = 1'b1;
      end
      if (r_q.unitCnt >= 32'(UNIT_CYC - 1)) begin
         r_d.unitCnt = 32'h0000_0000;
         if (period_q != 8'h00) begin
            if (r_q.perCnt >= period_q - 8'h01) begin
               r_d.perCnt   = 8'h00;
               r_d.compPend = 1'b1;
            end else begin
               r_d.perCnt = r_q.perCnt + 8'h01;
            end
         end
      end else begin
         r_d.unitCnt = r_q.unitCnt + 32'h0000_0001;
      end
      if (hostStoreWr && r_q.st != cscc_pkg::ST_LOAD) begin
         stWr     = 1'b1;
         stWrAddr = hostStoreAddr;
         stWrData = hostStoreData;
         r_d.pendIrq = 1'b1;
      end
      if (hostIrqAck) begin
         r_d.irqN = 1'b1;
      end
      if (r_q.pendIrq) begin
         r_d.irqN    = 1'b0; // set wins over acknowledge
         r_d.pendIrq = 1'b0;
      end
      case (r_q.st)
         cscc_pkg::ST_LOAD: begin
            // probe valid marker, then copy 16 words; read data lags one cycle
            r_d.nvmRd   = 1'b1;
            r_d.nvmAddr = r_q.ldCnt[3:0];
            if (r_q.ldCnt == 5'd0) begin
               r_d.ldCnt = 5'd1;
               r_d.nvmAddr = 4'h4;
            end else if (r_q.ldCnt == 5'd1) begin
               r_d.srcNvm  = (nvmRdData == cscc_pkg::NVM_VALID);
               r_d.ldCnt   = 5'd2;
               r_d.nvmAddr = 4'h0;
            end else begin
               stWr     = 1'b1;
               stWrAddr = 4'(r_q.ldCnt - 5'd2);
               stWrData = r_q.srcNvm ? nvmRdData : cscc_pkg::default_word(stWrAddr);
               r_d.nvmAddr = 4'(r_q.ldCnt - 5'd1);
               r_d.ldCnt   = r_q.ldCnt + 5'd1;
               if (r_q.ldCnt == 5'd17) begin
                  r_d.st       = cscc_pkg::ST_IDLE;
                  r_d.compPend = 1'b1;
                  r_d.irqN     = 1'b1;
               end
            end
         end
         cscc_pkg::ST_IDLE: begin
            if (r_q.burnPend) begin
               r_d.burnPend = 1'b0;
               r_d.ldCnt    = 5'd0;
               r_d.nvmAddr  = 4'h0;
               r_d.st       = cscc_pkg::ST_BURN;
            end else if (r_q.mode != cscc_pkg::MODE_SLEEP) begin
               r_d.comp     = r_q.compPend;
               r_d.compPend = 1'b0;
               r_d.bitPos   = 5'd15;
               r_d.idx      = 3'd0;
               r_d.st       = cscc_pkg::ST_MEAS;
               if (r_q.compPend) begin
                  for (int i = 0; i < 8; i++) begin
                     compVal_d[i] = cscc_pkg::COMP_MID;
                  end
               end
            end
         end
         cscc_pkg::ST_MEAS: begin
            nxt = next_en(enMask_q, {1'b0, r_q.idx});
            if (nxt[3]) begin
               r_d.st = r_q.comp ? cscc_pkg::ST_COMPCHK : cscc_pkg::ST_PROC;
            end else begin
               r_d.idx       = nxt[2:0];
               r_d.measStart = 1'b1;
               r_d.repeatCnt = rep_q[nxt[2:0]];
               r_d.offOut    = compVal_q[nxt[2:0]];
               r_d.st        = cscc_pkg::ST_WAIT;
            end
         end
         cscc_pkg::ST_WAIT: begin
            if (measDone) begin
               if (r_q.comp) begin
                  // positive residue means offset too small
                  if (measTicks > 0) begin
                     compVal_d[r_q.idx] = compVal_q[r_q.idx];
                  end else begin
                     compVal_d[r_q.idx][r_q.bitPos[3:0]] = 1'b0;
                  end
                  if (r_q.bitPos != 5'd0) begin
                     compVal_d[r_q.idx][r_q.bitPos[3:0] - 4'd1] = 1'b1;
                  end
               end
               if (r_q.idx == 3'd7) begin
                  r_d.st = r_q.comp ? cscc_pkg::ST_COMPCHK : cscc_pkg::ST_PROC;
               end else begin
                  r_d.idx = r_q.idx + 3'd1;
                  r_d.st  = cscc_pkg::ST_MEAS;
               end
            end
         end
         cscc_pkg::ST_COMPCHK: begin
            if (r_q.bitPos == 5'd0) begin
               r_d.comp    = 1'b0;
               r_d.pendIrq = 1'b1;
               r_d.st      = cscc_pkg::ST_IDLE;
            end else begin
               r_d.bitPos = r_q.bitPos - 5'd1;
               r_d.idx    = 3'd0;
               r_d.st     = cscc_pkg::ST_MEAS;
            end
         end
         cscc_pkg::ST_PROC: begin
            r_d.st = cscc_pkg::ST_IDLE;
         end
         cscc_pkg::ST_BURN: begin
            // read working word, written out one cycle later
            r_d.nvmAddr = r_q.ldCnt[3:0];
            r_d.st      = cscc_pkg::ST_BURNWT;
         end
         cscc_pkg::ST_BURNWT: begin
            r_d.nvmWr   = 1'b1;
            r_d.nvmData = stRdData;
            if (r_q.ldCnt == 5'd15) begin
               r_d.pendIrq = 1'b1;
               r_d.st      = cscc_pkg::ST_IDLE;
            end else begin
               r_d.ldCnt = r_q.ldCnt + 5'd1;
               r_d.st    = cscc_pkg::ST_BURN;
            end
         end
         default: r_d.st = cscc_pkg::ST_LOAD;
      endcase
   end

   always_ff @(posedge clk) begin
      if (anyReset) begin
         r_q <= '{st: cscc_pkg::ST_LOAD, mode: cscc_pkg::MODE_ACTIVE, irqN: 1'b0,
                  default: '0};
         for (int i = 0; i < 8; i++) begin
            compVal_q[i] <= cscc_pkg::COMP_RESET;
         end
      end else begin
         r_q <= r_d;
         for (int i = 0; i < 8; i++) begin
            compVal_q[i] <= compVal_d[i];
         end
      end
   end

   // outputs straight from flops; default store is a constant function
   assign measStart          = r_q.measStart;
   assign measInput          = r_q.idx;
   assign measRepeat         = r_q.repeatCnt;
   assign pinOffsetValue     = r_q.offOut;
   assign nvmRd              = r_q.nvmRd;
   assign nvmWr              = r_q.nvmWr;
   assign nvmAddr            = r_q.nvmAddr;
   assign nvmWrData          = r_q.nvmData;
   assign opMode             = r_q.mode;
   assign compBusy           = r_q.comp;
   assign configFromNvm      = r_q.srcNvm;
   assign tickAverage        = filtAvg;
   assign tickDeviation      = filtDev;
   assign interruptRequest_n = r_q.irqN;
endmodule // cap_sense_compensation_config
`default_nettype wire

// ==== hdl/cscc_pkg.sv ====
/*
 cscc_pkg: constants, modes and states shared by the sensing-path control logic.
 assumes a single 25 MHz clock domain; no bus, plain ports only.
*/
package cscc_pkg;
   localparam int NUM_INPUTS  = 8;
   localparam int IDX_W       = 3;
   localparam int TICK_W      = 16;
   localparam int COMP_W      = 16;
   localparam int REPEAT_W    = 8;
   localparam int STORE_WORDS = 16;
   localparam int STORE_AW    = 4;
   localparam int STORE_DW    = 8;
   localparam int FILT_SHIFT  = 3;

   // configuration word positions in the parameter stores
   localparam logic [3:0] ADDR_ENABLE     = 4'h0;
   localparam logic [3:0] ADDR_POS_THRESH = 4'h1;
   localparam logic [3:0] ADDR_NEG_THRESH = 4'h2;
   localparam logic [3:0] ADDR_PERIOD     = 4'h3;
   localparam logic [3:0] ADDR_REPEAT0    = 4'h8;

   localparam logic [15:0] COMP_RESET = 16'h0000;
   localparam logic [15:0] COMP_MID   = 16'h8000;
   localparam logic [7:0]  NVM_VALID  = 8'hA5;

   // scan-period interval unit for periodic compensation
   localparam int PERIOD_UNIT_NS  = 1_000_000;
   localparam int CLK_PERIOD_NS   = 40;
   localparam int PERIOD_UNIT_CYC = PERIOD_UNIT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      MODE_ACTIVE = 2'b00,
      MODE_DOZE   = 2'b01,
      MODE_SLEEP  = 2'b10
   } cscc_mode_t;

   typedef enum logic [7:0] {
      ST_LOAD    = 8'b0000_0001,
      ST_IDLE    = 8'b0000_0010,
      ST_MEAS    = 8'b0000_0100,
      ST_WAIT    = 8'b0000_1000,
      ST_PROC    = 8'b0001_0000,
      ST_BURN    = 8'b0010_0000,
      ST_COMPCHK = 8'b0100_0000,
      ST_BURNWT  = 8'b1000_0000
   } cscc_state_t;

   // fixed default contents, read only by construction
   function automatic logic [7:0] default_word(input logic [3:0] a);
      case (a)
         4'h0:    default_word = 8'hFF;
         4'h1:    default_word = 8'h40;
         4'h2:    default_word = 8'h40;
         4'h3:    default_word = 8'h10;
         4'h4:    default_word = NVM_VALID;
         default: default_word = (a >= 4'h8) ? 8'h10 : 8'h00;
      endcase
   endfunction
endpackage

// ==== hdl/cscc_store.sv ====
/*
 cscc_store: small working parameter store, one write port, registered read.
 assumes synchronous active-low reset clears it; contents lost on reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cscc_store #(
   parameter int AW = 4,
   parameter int DW = 8
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rstn,
   // write port
   input  wire logic          wrEn,
   input  wire logic [AW-1:0] wrAddr,
   input  wire logic [DW-1:0] wrData,
   // read port
   input  wire logic [AW-1:0] rdAddr,
   output var  logic [DW-1:0] rdData
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int i = 0; i < (1<<AW); i++) begin
            mem[i] <= '0;
         end
         rdData <= '0;
      end else begin
         if (wrEn) begin
            mem[wrAddr] <= wrData;
         end
         rdData <= mem[rdAddr];
      end
   end
endmodule // cscc_store
`default_nettype wire

// ==== hdl/cscc_filter.sv ====
/*
 cscc_filter: per-input low pass of raw ticks and fast deviation.
 assumes one sample presented per strobe with its input index.
*/
`timescale 1ns/1ps
`default_nettype none
module cscc_filter #(
   parameter int N  = 8,
   parameter int IW = 3,
   parameter int TW = 16,
   parameter int SH = 3
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // sample in
   input  wire logic                 sampleValid,
   input  wire logic [IW-1:0]        sampleIdx,
   input  wire logic signed [TW-1:0] sampleTicks,
   // results
   output var  logic signed [TW-1:0] tickAverage,
   output var  logic signed [TW-1:0] tickDeviation,
   output var  logic                 resultValid
);
   logic signed [TW-1:0] avg_q [0:N-1];
   logic signed [TW-1:0] cur;
   logic signed [TW-1:0] nxt;

   assign cur = avg_q[sampleIdx];
   // first-order iir: avg += (raw - avg) >>> shift
   assign nxt = TW'(cur + ((sampleTicks - cur) >>> SH));

   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int i = 0; i < N; i++) begin
            avg_q[i] <= '0;
         end
         tickAverage   <= '0;
         tickDeviation <= '0;
         resultValid   <= 1'b0;
      end else begin
         resultValid <= sampleValid;
         if (sampleValid) begin
            avg_q[sampleIdx] <= nxt;
            tickAverage      <= nxt;
            tickDeviation    <= TW'(sampleTicks - nxt);
         end
      end
   end
endmodule // cscc_filter
`default_nettype wire

// ==== test/cscc_assertions.sv ====
/*
 cscc_assertions: port-level properties of the sensing-path control block.
 assumes it is bound to cap_sense_compensation_config and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module cscc_assertions (
   // observed ports
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        softReset,
   input wire logic [1:0]  hostMode,
   input wire logic        hostModeWr,
   input wire logic        hostCompReq,
   input wire logic        hostIrqAck,
   input wire logic        measStart,
   input wire logic [2:0]  measInput,
   input wire logic [7:0]  measRepeat,
   input wire logic [15:0] pinOffsetValue,
   input wire logic        nvmWr,
   input wire logic [3:0]  nvmAddr,
   input wire logic [1:0]  opMode,
   input wire logic        compBusy,
   input wire logic        interruptRequest_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn || softReset);
   // load phase ends when the request line first rises
   logic loaded_q;
   always_ff @(posedge clk) begin
      loaded_q <= (!rstn || softReset) ? 1'b0 : (loaded_q | interruptRequest_n);
   end
   property p_resetIrq;
      disable iff (1'b0) !rstn |=> !interruptRequest_n && opMode == 2'b00 && !measStart && !nvmWr;
   endproperty
   a_resetIrq: assert property (p_resetIrq) else $error("reset state wrong");
   property p_loadHold;
      $rose(rstn) |-> !interruptRequest_n [*8];
   endproperty
   a_loadHold: assert property (p_loadHold) else $error("irq rose during load");
   property p_startPulse;
      measStart |=> !measStart;
   endproperty
   a_startPulse: assert property (p_startPulse) else $error("start not a pulse");
   property p_measHold;
      measStart |=> ($stable(measInput) && $stable(measRepeat) && $stable(pinOffsetValue)) [*2];
   endproperty
   a_measHold: assert property (p_measHold) else $error("setup moved in measurement");
   property p_sleepMode;
      hostModeWr && hostMode == 2'b10 |-> ##[1:3] opMode == 2'b10;
   endproperty
   a_sleepMode: assert property (p_sleepMode) else $error("sleep not entered");
   property p_sleepRefuse;
      opMode == 2'b10 && !compBusy && hostCompReq |=> !compBusy;
   endproperty
   a_sleepRefuse: assert property (p_sleepRefuse) else $error("comp started in sleep");
   property p_irqStands;
      loaded_q && !interruptRequest_n && !hostIrqAck |=> !interruptRequest_n;
   endproperty
   a_irqStands: assert property (p_irqStands) else $error("irq released unasked");
   property p_burnAll;
      nvmWr && nvmAddr == 4'h0 |-> ##[1:300] nvmWr && nvmAddr == 4'hF;
   endproperty
   a_burnAll: assert property (p_burnAll) else $error("copy stopped short");
endmodule // cscc_assertions
`default_nettype wire

// ==== test/cscc_partner.sv ====
/*
 cscc_partner: behavioural front end and non-volatile word memory.
 assumes the block's measStart pulse and a combinational memory read.
*/
`timescale 1ns/1ps
`default_nettype none
module cscc_partner (
   // clock
   input wire logic         clk,
   // front end
   input wire logic         measStart,
   input wire logic [2:0]   measInput,
   input wire logic [7:0]   measRepeat,
   input wire logic [15:0]  pinOffsetValue,
   input wire logic [15:0]  drift,
   output logic             measDone,
   output logic signed [15:0] measTicks,
   // memory
   input wire logic         nvmRd,
   input wire logic         nvmWr,
   input wire logic [3:0]   nvmAddr,
   input wire logic [7:0]   nvmWrData,
   output logic [7:0]       nvmRdData
);
   logic [7:0] mem [16];
   int         waitN = 0;
   int         t;
   initial begin
      mem = '{default: 8'h00};
      measDone = 1'b0;
      measTicks = 16'h0000;
   end
   // residual after offset; input index spreads the external load
   always_comb begin
      t = int'(16'h1234 + {1'b0, measInput, 12'h000} + drift) - int'(pinOffsetValue);
      if (t > 32767) t = 32767;
      if (t < -32768) t = -32768;
   end
   assign nvmRdData = nvmRd ? mem[nvmAddr] : ~mem[nvmAddr];
   always @(posedge clk) begin
      measDone <= 1'b0;
      measTicks <= ~measTicks; // no stale value outside the done cycle
      if (measStart) waitN <= 2 + int'(measRepeat[2:0]);
      else if (waitN > 0) waitN <= waitN - 1;
      if (waitN == 1 && !measStart) begin
         measDone <= 1'b1;
         measTicks <= 16'(t);
      end
      if (nvmWr) mem[nvmAddr] <= nvmWrData;
   end
endmodule // cscc_partner
`default_nettype wire

// ==== test/cap_sense_compensation_config_test.sv ====
/*
 cap_sense_compensation_config_test: self-checking bench of the block.
 assumes the partner model, the bound checker and one 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cap_sense_compensation_config_test;
   logic clk = 1'b0, rstn = 1'b0, softReset = 1'b0, measDone, nvmRd, nvmWr, measStart;
   logic hostModeWr = 1'b0, hostCompReq = 1'b0, hostStoreWr = 1'b0, hostBurnReq = 1'b0;
   logic hostIrqAck = 1'b0, compBusy, configFromNvm, interruptRequest_n;
   logic [1:0]  hostMode = 2'h0, opMode;
   logic [3:0]  hostStoreAddr = 4'h0, nvmAddr;
   logic [7:0]  hostStoreData = 8'h00, measRepeat, nvmWrData, nvmRdData;
   logic [2:0]  measInput, prev;
   logic [15:0] pinOffsetValue, drift = 16'h0000;
   logic signed [15:0] measTicks;
   logic [1:0]  rows [5] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h0};
   int nErrors = 0, cmpCount = 0, cycles = 0, n, k;
   always #20 clk = ~clk;
   cap_sense_compensation_config #(.UNIT_CYC(10)) dut_u (.clk, .rstn, .softReset, .hostMode,
      .hostModeWr, .hostCompReq, .hostStoreWr, .hostStoreAddr, .hostStoreData, .hostBurnReq,
      .hostIrqAck, .measStart, .measInput, .measRepeat, .pinOffsetValue, .measDone,
      .measTicks, .nvmRd, .nvmWr, .nvmAddr, .nvmWrData, .nvmRdData, .opMode, .compBusy,
      .configFromNvm, .tickAverage(), .tickDeviation(), .interruptRequest_n);
   cscc_partner partner_u (.clk, .measStart, .measInput, .measRepeat, .pinOffsetValue,
      .drift, .measDone, .measTicks, .nvmRd, .nvmWr, .nvmAddr, .nvmWrData, .nvmRdData);
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
      if (nErrors == 0 && cmpCount > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmpCount++;
      if (got !== exp) begin
         nErrors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one-cycle host strobe; 0 mode, 1 comp, 2 store, 3 copy, 4 ack
   task automatic pulse(input int s);
      @(posedge clk);
      case (s)
         0: hostModeWr <= 1'b1;
         1: hostCompReq <= 1'b1;
         2: hostStoreWr <= 1'b1;
         3: hostBurnReq <= 1'b1;
         default: hostIrqAck <= 1'b1;
      endcase
      @(posedge clk);
      {hostModeWr, hostCompReq, hostStoreWr, hostBurnReq, hostIrqAck} <= 5'h00;
   endtask
   // bounded wait for irq (0) or busy (1) to reach a level
   task automatic waitSig(input int s, input logic lvl, input int lim);
      n = 0;
      @(posedge clk);
      while (((s == 0) ? interruptRequest_n : compBusy) !== lvl && n < lim) begin
         @(posedge clk);
         n++;
      end
      check({15'h0, (s == 0) ? interruptRequest_n : compBusy}, {15'h0, lvl});
   endtask
   // writes are dropped during load, so retry until the irq confirms it
   task automatic storeWr(input logic [3:0] a, input logic [7:0] d);
      hostStoreAddr <= a;
      hostStoreData <= d;
      for (k = 0; k < 60; k++) begin
         pulse(4);
         pulse(2);
         repeat (3) @(posedge clk);
         if (interruptRequest_n === 1'b0) break;
      end
      check({15'h0, interruptRequest_n}, 16'h0000);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         nErrors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      waitSig(0, 1'b1, 200);
      check({15'h0, configFromNvm}, 16'h0000);
      waitSig(1, 1'b0, 20000);
      waitSig(0, 1'b0, 4);
      foreach (rows[i]) begin
         hostMode <= rows[i];
         pulse(0);
         for (n = 0; n < 10 && opMode !== rows[i]; n++) @(posedge clk);
         check({14'h0, opMode}, {14'h0, rows[i]});
      end
      hostMode <= 2'h2;
      pulse(0);
      waitSig(1, 1'b0, 20000);
      pulse(1);
      repeat (5) @(posedge clk);
      check({15'h0, compBusy}, 16'h0000);
      hostMode <= 2'h0;
      pulse(0);
      pulse(4);
      pulse(1);
      waitSig(1, 1'b1, 10);
      waitSig(1, 1'b0, 20000);
      waitSig(0, 1'b0, 4);
      storeWr(4'h3, 8'h00);
      storeWr(4'h0, 8'h05);
      storeWr(4'h8, 8'h03);
      storeWr(4'hA, 8'h07);
      pulse(4);
      pulse(1);
      waitSig(1, 1'b0, 20000);
      pulse(4);
      pulse(3);
      for (n = 0; n < 3000 && !(nvmWr === 1'b1 && nvmAddr === 4'hF); n++) @(posedge clk);
      waitSig(0, 1'b0, 4);
      check({8'h0, partner_u.mem[0]}, 16'h0005);
      check({8'h0, partner_u.mem[10]}, 16'h0007);
      check({8'h0, partner_u.mem[4]}, 16'h00A5);
      @(posedge clk);
      softReset <= 1'b1;
      repeat (2) @(posedge clk);
      softReset <= 1'b0;
      waitSig(0, 1'b1, 200);
      check({15'h0, configFromNvm}, 16'h0001);
      waitSig(1, 1'b0, 20000);
      for (n = 0; n < 4000 && !(measStart === 1'b1 && measInput === 3'h0); n++) @(posedge clk);
      check({15'h0, pinOffsetValue == 16'h1233 || pinOffsetValue == 16'h1234}, 16'h0001);
      prev = 3'h0;
      for (k = 0; k < 3 && n < 8000; n++) begin
         @(posedge clk);
         if (measStart === 1'b1) begin
            check({13'h0, measInput}, (prev == 3'h0) ? 16'h0002 : 16'h0000);
            check({8'h0, measRepeat}, (measInput == 3'h0) ? 16'h0003 : 16'h0007);
            prev = measInput;
            k++;
         end
      end
      drift <= 16'h0100;
      waitSig(1, 1'b1, 3000);
      waitSig(1, 1'b0, 20000);
      storeWr(4'h3, 8'h10);
      waitSig(1, 1'b1, 5000);
      waitSig(1, 1'b0, 20000);
      report_and_stop();
   end
endmodule // cap_sense_compensation_config_test
bind cap_sense_compensation_config cscc_assertions chk_u (.clk, .rstn, .softReset, .hostMode,
   .hostModeWr, .hostCompReq, .hostIrqAck, .measStart, .measInput, .measRepeat,
   .pinOffsetValue, .nvmWr, .nvmAddr, .opMode, .compBusy, .interruptRequest_n);
`default_nettype wire
